// *** hw/fbi_regs.vh ***
// Constants for the flash bus host controller.
// Assumes inclusion by the host controller files only.
`ifndef FBI_REGS_VH
`define FBI_REGS_VH
// Bus timing in ns, plain defaults to be set per part, and the clock period
`define FBI_CLK_PERIOD_NS 20
`define FBI_ACCESS_NS 50
`define FBI_WRITE_PULSE_NS 50
`define FBI_SETUP_NS 20
`define FBI_IDLE_STANDBY_NS 150
// Operation codes on the host command port
`define FBI_OP_READ 2'h0
`define FBI_OP_WRITE 2'h1
`define FBI_OP_SIG 2'h2
// Address bit positions with special meaning
`define FBI_ADDR_SIG_BIT 1
`define FBI_ADDR_LSB 0
// Top data pin, which carries the byte select in byte mode
`define FBI_DQ_TOP 15
// Lane enables: all lanes, low byte only, top pin only
`define FBI_LANES_WORD 16'hffff
`define FBI_LANES_BYTE 16'h00ff
`define FBI_LANES_TOP 16'h8000
// Extra read wait that covers the two-flop input synchroniser
`define FBI_SYNC_EXTRA 4'h2
`endif

// *** hw/fbi_sync.v ***
// Two-stage synchroniser for a vector of pin inputs.
// Assumes its inputs are asynchronous to clk.
`timescale 1ns/100ps
module fbi_sync #(
    parameter WIDTH = 16
) (
    input wire clk,
    input wire nrst,
    input wire ce,
    input wire [WIDTH-1:0] d,
    output reg [WIDTH-1:0] q
);
    reg [WIDTH-1:0] meta_reg; // First stage, read only by q
    ////////////////////////////////////////////////////////////////
    // Two flops in series
    always @(posedge clk or negedge nrst) begin
        if (!nrst) begin
            meta_reg <= {WIDTH{1'b0}};
            q <= {WIDTH{1'b0}};
        end else if (ce) begin
            meta_reg <= d;
            q <= meta_reg;
        end
    end
endmodule // fbi_sync

// *** hw/fbi_host.v ***
// Host-side controller driving an asynchronous parallel flash bus.
// Assumes a single 50 MHz clock; flash pins are wired via the bench.
// How it works
// - Read: select, output enable low, write high
// - Write: address set before later falling edge
// - Data held valid around first rising edge
// - Output enable stays high during writes
// - Signature read: elevated select, address bit1 low
`timescale 1ns/100ps
`include "fbi_regs.vh"
module fbi_host #(
    parameter AW = 18, // Word address width
    parameter ACC_CYC = (`FBI_ACCESS_NS + `FBI_CLK_PERIOD_NS - 1) / `FBI_CLK_PERIOD_NS,
    parameter WP_CYC = (`FBI_WRITE_PULSE_NS + `FBI_CLK_PERIOD_NS - 1) / `FBI_CLK_PERIOD_NS,
    parameter SU_CYC = (`FBI_SETUP_NS + `FBI_CLK_PERIOD_NS - 1) / `FBI_CLK_PERIOD_NS
) (
    input wire CORE_CLK,
    input wire NRST,
    input wire CLK_EN,
    // User command port
    input wire REQ_VALID,
    input wire [1:0] REQ_OP,
    input wire [AW-1:0] REQ_ADDR,
    input wire [15:0] REQ_WDATA,
    input wire BYTE_MODE,
    input wire SUPPLY_OK,
    output reg REQ_READY,
    output reg RSP_VALID,
    output reg [15:0] RSP_RDATA,
    output reg REQ_REFUSED,
    // Flash pins
    output reg FL_CE_N,
    output reg FL_OE_N,
    output reg FL_WE_N,
    output reg [AW-1:0] FL_ADDR,
    output reg FL_SIG_HV,
    output reg FL_BYTE_N,
    input wire [15:0] FL_DQ_IN,
    output reg [15:0] FL_DQ_OUT,
    output reg [15:0] FL_DQ_OE
);
    ////////////////////////////////////////////////////////////////
    // States, one-hot
    localparam S_IDLE = 6'h01;
    localparam S_SETUP = 6'h02; // Address settles, strobes high
    localparam S_RDWAIT = 6'h04; // Select and OE low, waiting access
    localparam S_WRPULSE = 6'h08; // Select and WE low
    localparam S_WRHOLD = 6'h10; // WE high, data still driven
    localparam S_DONE = 6'h20; // Strobes high, data released
    localparam CW = 4;
    localparam [CW-1:0] ACC_N = ACC_CYC[CW-1:0];
    localparam [CW-1:0] WP_N = WP_CYC[CW-1:0];
    localparam [CW-1:0] SU_N = SU_CYC[CW-1:0];

    // Data lane enables for the current bus width: all lanes, or low byte only
    function [15:0] lane_mask;
        input byte_n;
        begin
            lane_mask = byte_n ? `FBI_LANES_WORD : `FBI_LANES_BYTE;
        end
    endfunction

    reg [5:0] state_reg, state_next;
    reg [CW-1:0] cnt_reg, cnt_next;
    reg is_wr_reg; // Current op is a write
    wire [15:0] dq_sync; // Flash data after two flops
    wire supply_sync; // Supply lockout level after two flops
    wire [16:0] sync_out;

    fbi_sync #(.WIDTH(17)) u_sync (
        .clk(CORE_CLK),
        .nrst(NRST),
        .ce(CLK_EN),
        .d({SUPPLY_OK, FL_DQ_IN}),
        .q(sync_out)
    );
    assign dq_sync = sync_out[15:0];
    assign supply_sync = sync_out[16];

    ////////////////////////////////////////////////////////////////
    // Next-state logic
    always @* begin
        state_next = state_reg;
        cnt_next = cnt_reg;
        case (state_reg)
            S_IDLE: begin
                if (REQ_VALID && REQ_READY) begin
                    state_next = S_SETUP;
                    cnt_next = SU_N;
                end
            end
            S_SETUP: begin
                // Address stable before the strobes fall
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    state_next = is_wr_reg ? S_WRPULSE : S_RDWAIT;
                    // Two extra cycles cover the input synchroniser
                    cnt_next = is_wr_reg ? WP_N : ACC_N + `FBI_SYNC_EXTRA;
                end
            end
            S_RDWAIT, S_WRPULSE: begin
                // Strobe width well above glitch filter
                if (cnt_reg > 4'h1) begin
                    cnt_next = cnt_reg - 4'h1;
                end else begin
                    state_next = (state_reg == S_RDWAIT) ? S_DONE : S_WRHOLD;
                end
            end
            S_WRHOLD: state_next = S_DONE;
            S_DONE: state_next = S_IDLE;
            default: state_next = S_IDLE;
        endcase
    end

    ////////////////////////////////////////////////////////////////
    // State, pins and answers, all registered
    always @(posedge CORE_CLK or negedge NRST) begin
        if (!NRST) begin
            state_reg <= S_IDLE;
            cnt_reg <= {CW{1'b0}};
            is_wr_reg <= 1'b0;
            REQ_READY <= 1'b0;
            RSP_VALID <= 1'b0;
            RSP_RDATA <= 16'h0000;
            REQ_REFUSED <= 1'b0;
            FL_CE_N <= 1'b1;
            FL_OE_N <= 1'b1;
            FL_WE_N <= 1'b1;
            FL_ADDR <= {AW{1'b0}};
            FL_SIG_HV <= 1'b0;
            FL_BYTE_N <= 1'b1;
            FL_DQ_OUT <= 16'h0000;
            FL_DQ_OE <= 16'h0000;
        end else if (CLK_EN) begin
            state_reg <= state_next;
            cnt_reg <= cnt_next;
            RSP_VALID <= 1'b0;
            REQ_REFUSED <= 1'b0;
            REQ_READY <= (state_next == S_IDLE) && !(REQ_VALID && REQ_READY);
            case (state_reg)
                S_IDLE: begin
                    if (REQ_VALID && REQ_READY) begin
                        if (REQ_OP == `FBI_OP_WRITE && !supply_sync) begin
                            // Supply locked out: never start a write
                            state_reg <= S_IDLE;
                            REQ_REFUSED <= 1'b1;
                            REQ_READY <= 1'b1;
                        end else begin
                            is_wr_reg <= (REQ_OP == `FBI_OP_WRITE);
                            // Byte mode: pins carry the word, the top data pin the byte
                            // Limitation: in byte mode the top address pin stays low
                            FL_ADDR <= BYTE_MODE ? (REQ_ADDR >> 1) : REQ_ADDR;
                            FL_BYTE_N <= !BYTE_MODE;
                            // Signature: select pin high, address bit 1 low
                            FL_SIG_HV <= (REQ_OP == `FBI_OP_SIG);
                            if (REQ_OP == `FBI_OP_SIG) begin
                                FL_ADDR[`FBI_ADDR_SIG_BIT] <= 1'b0;
                            end
                            // Byte mode: lowest address on top data pin
                            FL_DQ_OUT <= REQ_WDATA;
                            if (BYTE_MODE) begin
                                FL_DQ_OUT[`FBI_DQ_TOP] <= REQ_ADDR[`FBI_ADDR_LSB];
                            end
                            FL_DQ_OE <= BYTE_MODE ? `FBI_LANES_TOP : 16'h0000;
                        end
                    end
                end
                S_SETUP: begin
                    if (state_next != S_SETUP) begin
                        FL_CE_N <= 1'b0;
                        if (is_wr_reg) begin
                            FL_WE_N <= 1'b0;
                            FL_OE_N <= 1'b1;
                            FL_DQ_OE <= lane_mask(FL_BYTE_N) | FL_DQ_OE;
                        end else begin
                            FL_OE_N <= 1'b0;
                        end
                    end
                end
                S_RDWAIT: begin
                    if (state_next == S_DONE) begin
                        RSP_RDATA <= dq_sync & lane_mask(FL_BYTE_N);
                        RSP_VALID <= 1'b1;
                        FL_OE_N <= 1'b1;
                        FL_CE_N <= 1'b1;
                    end
                end
                S_WRPULSE: begin
                    if (state_next == S_WRHOLD) begin
                        // Both strobes rise together; data still held
                        FL_WE_N <= 1'b1;
                        FL_CE_N <= 1'b1;
                    end
                end
                S_WRHOLD: begin
                    FL_DQ_OE <= 16'h0000;
                    RSP_VALID <= 1'b1;
                end
                S_DONE: begin
                    FL_SIG_HV <= 1'b0;
                    FL_DQ_OE <= 16'h0000;
                end
                default: begin
                    FL_CE_N <= 1'b1;
                end
            endcase
        end
    end
endmodule // fbi_host

// *** tb/fbi_host_sva.sv ***
// Pin-timing checker for the flash host controller.
// Assumes a bind onto fbi_host with CLK_EN held high.
`timescale 1ns/100ps
module fbi_host_sva #(
    parameter AW = 18
) (
    input wire CORE_CLK,
    input wire NRST,
    input wire RSP_VALID,
    input wire REQ_REFUSED,
    input wire FL_CE_N,
    input wire FL_OE_N,
    input wire FL_WE_N,
    input wire [AW-1:0] FL_ADDR,
    input wire FL_SIG_HV,
    input wire FL_BYTE_N,
    input wire [15:0] FL_DQ_OUT,
    input wire [15:0] FL_DQ_OE
);
    default clocking @(posedge CORE_CLK); endclocking
    default disable iff (!NRST);
    ////////////////////////////////////////////////////////////////////////////
    // Strobe phases, in cycles of the counts the design was built with
    sequence s_wlow; !FL_WE_N [*3]; endsequence
    sequence s_rlow; !FL_OE_N [*5]; endsequence
    property p_rd; !FL_OE_N |-> FL_WE_N && !FL_CE_N; endproperty
    a_rd: assert property (p_rd) else $error("read strobes wrong");
    property p_wr; !FL_WE_N |-> FL_OE_N && !FL_CE_N; endproperty
    a_wr: assert property (p_wr) else $error("output enable low in write");
    property p_rel; !FL_OE_N |-> FL_DQ_OE[14:0] == 15'h0 && FL_DQ_OE[15] == !FL_BYTE_N;
    endproperty
    a_rel: assert property (p_rel) else $error("host drives data in read");
    property p_data; $rose(FL_WE_N) |-> $stable(FL_DQ_OUT) && FL_DQ_OE != 16'h0; endproperty
    a_data: assert property (p_data) else $error("write data not held");
    property p_addr; $fell(FL_WE_N) |-> $stable(FL_ADDR); endproperty
    a_addr: assert property (p_addr) else $error("address moves at strobe");
    property p_wpulse; $fell(FL_WE_N) |-> s_wlow ##1 FL_WE_N; endproperty
    a_wpulse: assert property (p_wpulse) else $error("write pulse length");
    property p_rlat; $fell(FL_OE_N) |-> s_rlow ##1 (FL_OE_N && RSP_VALID); endproperty
    a_rlat: assert property (p_rlat) else $error("read length wrong");
    property p_sig; FL_SIG_HV && !FL_OE_N |-> !FL_ADDR[1]; endproperty
    a_sig: assert property (p_sig) else $error("signature address bit");
    // Two cycles, so a write wrongly started at the refusal is caught
    property p_lock; REQ_REFUSED |-> (FL_WE_N && FL_CE_N) [*2]; endproperty
    a_lock: assert property (p_lock) else $error("strobe on refused write");
endmodule // fbi_host_sva
bind fbi_host fbi_host_sva #(.AW(AW)) i_sva (.CORE_CLK(CORE_CLK), .NRST(NRST),
    .RSP_VALID(RSP_VALID), .REQ_REFUSED(REQ_REFUSED), .FL_CE_N(FL_CE_N), .FL_OE_N(FL_OE_N),
    .FL_WE_N(FL_WE_N), .FL_ADDR(FL_ADDR), .FL_SIG_HV(FL_SIG_HV), .FL_BYTE_N(FL_BYTE_N),
    .FL_DQ_OUT(FL_DQ_OUT), .FL_DQ_OE(FL_DQ_OE));

// *** tb/fbi_flash_model.sv ***
// Behavioural flash device on the far side of the host controller.
// Assumes the bench joins its pins to fbi_host; no command sequences.
`timescale 1ns/100ps
module fbi_flash_model #(
    parameter AW = 18,
    parameter [15:0] MAKER_CODE = 16'h0a5c, // Arbitrary value
    parameter [15:0] PART_CODE = 16'h0c3a // Arbitrary value
) (
    input wire ce_n,
    input wire oe_n,
    input wire we_n,
    input wire [AW-1:0] addr,
    input wire sig_hv,
    input wire byte_n,
    input wire supply_ok,
    input wire [15:0] dq_out,
    input wire [15:0] dq_oe,
    output wire [15:0] dq_in
);
    reg [15:0] mem [0:255];
    reg [15:0] idle_reg = 16'h5a5a; // Released lines wander, never hold
    reg [7:0] wa_reg;
    reg wb_reg;
    reg wr_reg = 1'b0;
    always #10 idle_reg = ~idle_reg;
    // Address at the later falling edge; no protected blocks are set
    always @(negedge ce_n or negedge we_n) #1 if (!ce_n && !we_n) begin
        wa_reg = addr[7:0];
        wb_reg = dq_out[15];
        wr_reg = supply_ok;
    end
    // Data at the first rising edge
    always @(posedge ce_n or posedge we_n) if (wr_reg) begin
        wr_reg = 1'b0;
        if (byte_n) mem[wa_reg] = dq_out;
        else if (wb_reg) mem[wa_reg][15:8] = dq_out[7:0];
        else mem[wa_reg][7:0] = dq_out[7:0];
    end
    wire rd = !ce_n && !oe_n && we_n;
    wire [15:0] word = (sig_hv && !addr[1]) ? (addr[0] ? PART_CODE : MAKER_CODE)
        : mem[addr[7:0]];
    wire [7:0] bsel = dq_out[15] ? word[15:8] : word[7:0];
    assign dq_in = (dq_oe & dq_out) | (~dq_oe & (rd ? (byte_n ? word
        : {idle_reg[15:8], bsel}) : idle_reg));
endmodule // fbi_flash_model

// *** tb/tb_fbi_host.sv ***
// Self-checking bench: host controller against the flash model.
// Assumes the checker is bound and the model accepts plain writes.
`timescale 1ns/100ps
module tb_fbi_host;
    localparam [15:0] MAKER = 16'h0a5c; // Arbitrary value
    localparam [15:0] PART = 16'h0c3a; // Arbitrary value
    reg clk = 1'b0;
    reg nrst = 1'b0;
    reg req_valid = 1'b0;
    reg [1:0] req_op = 2'h0;
    reg [17:0] req_addr = 18'h0;
    reg [15:0] req_wdata = 16'h0;
    reg byte_mode = 1'b0;
    reg supply_ok = 1'b1;
    wire req_ready, rsp_valid, req_refused, ce_n, oe_n, we_n, sig_hv, byte_n;
    wire [15:0] rsp_rdata, dq_in, dq_out, dq_oe;
    wire [17:0] fl_addr;
    reg [18:0] exp_q [$];
    reg [18:0] e;
    reg [15:0] shadow [0:255];
    integer fails = 0;
    integer num_checks = 0;
    integer i;
    initial forever #10 clk = ~clk;
    fbi_host i_dut (.CORE_CLK(clk), .NRST(nrst), .CLK_EN(1'b1), .REQ_VALID(req_valid),
        .REQ_OP(req_op), .REQ_ADDR(req_addr), .REQ_WDATA(req_wdata), .BYTE_MODE(byte_mode),
        .SUPPLY_OK(supply_ok), .REQ_READY(req_ready), .RSP_VALID(rsp_valid),
        .RSP_RDATA(rsp_rdata), .REQ_REFUSED(req_refused), .FL_CE_N(ce_n), .FL_OE_N(oe_n),
        .FL_WE_N(we_n), .FL_ADDR(fl_addr), .FL_SIG_HV(sig_hv), .FL_BYTE_N(byte_n),
        .FL_DQ_IN(dq_in), .FL_DQ_OUT(dq_out), .FL_DQ_OE(dq_oe));
    fbi_flash_model #(.MAKER_CODE(MAKER), .PART_CODE(PART)) i_flash (.ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .addr(fl_addr), .sig_hv(sig_hv), .byte_n(byte_n),
        .supply_ok(supply_ok), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
    ////////////////////////////////////////////////////////////////////////////
    task stop_test;
        begin
            $display("checks %0d fails %0d", num_checks, fails);
            if (fails == 0 && num_checks > 0) $display("Result: passed");
            else $display("Result: failed");
            $finish;
        end
    endtask
    // Queue the outcome, hold the request until taken
    task req(input [1:0] op, input [17:0] a, input [15:0] d, input [18:0] ex);
        integer n;
        begin
            exp_q.push_back(ex);
            req_op = op;
            req_addr = a;
            req_wdata = d;
            req_valid = 1'b1;
            n = 0;
            while (req_ready !== 1'b1) begin
                @(negedge clk);
                n = n + 1;
                if (n > 40) begin
                    fails = fails + 1;
                    $display("ERROR %0t: request never taken", $time);
                    stop_test;
                end
            end
            @(negedge clk);
            req_valid = 1'b0;
        end
    endtask
    // Oldest note against each pulse: {refused, valid, is read, data}
    always @(negedge clk) if (rsp_valid === 1'b1 || req_refused === 1'b1) begin
        e = exp_q.pop_front();
        num_checks = num_checks + 1;
        if ({req_refused, rsp_valid} !== e[18:17] || (e[16] && rsp_rdata !== e[15:0])) begin
            fails = fails + 1;
            $display("ERROR %0t: got %h expected %h", $time, rsp_rdata, e);
        end
    end
    initial begin
        e = $urandom(19811);
        repeat (12) @(negedge clk);
        nrst = 1'b1;
        repeat (3) @(negedge clk);
        for (i = 0; i < 8; i = i + 1) begin
            shadow[i] = $urandom;
            req(2'h1, ($urandom & 18'h3ff00) | i, shadow[i], 19'h20000);
        end
        for (i = 0; i < 8; i = i + 1)
            req(i[0] ? 2'h3 : 2'h0, ($urandom & 18'h3ff00) | i, 0, {3'b011, shadow[i]});
        supply_ok = 1'b0;
        repeat (3) @(negedge clk);
        req(2'h1, 18'h5, 16'h1234, 19'h40000);
        supply_ok = 1'b1;
        repeat (3) @(negedge clk);
        req(2'h0, 18'h5, 0, {3'b011, shadow[5]});
        for (i = 0; i < 2; i = i + 1)
            req(2'h2, ($urandom & 18'h3fffc) | 2 | i, 0, {3'b011, i ? PART : MAKER});
        byte_mode = 1'b1;
        for (i = 0; i < 4; i = i + 1) begin
            shadow[128 + i] = $urandom & 16'hff;
            req(2'h1, 18'h80 + i, shadow[128 + i], 19'h20000);
        end
        for (i = 0; i < 4; i = i + 1)
            req(2'h0, 18'h80 + i, 0, {3'b011, shadow[128 + i]});
        i = 0;
        while (exp_q.size() != 0 && i < 100) begin
            @(negedge clk);
            i = i + 1;
        end
        if (i >= 100) begin
            fails = fails + 1;
            $display("ERROR %0t: answers still missing", $time);
        end
        stop_test;
    end
endmodule // tb_fbi_host
